// *** src/rss_pkg.sv ***
// package: register map, field positions, reset values and timing constants
package rss_pkg;

   // ***************************************************************
   // clock and delay times
   // ***************************************************************
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned T100_MS       = 100;
   localparam int unsigned T500_MS       = 500;
   localparam int unsigned T1_S          = 1;
   localparam int unsigned T5_S          = 5;
   localparam int unsigned CYC_100MS     = CLK_HZ / 1000 * T100_MS;
   localparam int unsigned CYC_500MS     = CLK_HZ / 1000 * T500_MS;
   localparam int unsigned CYC_1S        = CLK_HZ * T1_S;
   localparam int unsigned CYC_5S        = CLK_HZ * T5_S;
   localparam int unsigned TMR_W         = 28;

   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_CFG2      = 8'h08;
   localparam logic [7:0] ADDR_CFG3      = 8'h0C;
   localparam logic [7:0] ADDR_SHUTDOWN  = 8'h14;
   localparam logic [7:0] ADDR_FAULT     = 8'h18;
   localparam logic [7:0] ADDR_STATUS    = 8'h1C;

   // ***************************************************************
   // fields and values
   // ***************************************************************
   localparam int unsigned CFG2_RST_LSB  = 2;
   localparam int unsigned FLT_OV        = 7;
   localparam int unsigned FLT_UV        = 6;
   localparam int unsigned FLT_OC        = 5;
   localparam int unsigned FLT_RETRY     = 4;
   localparam logic [7:0] SHUT_ON        = 8'hAA;
   localparam logic [7:0] SHUT_OFF       = 8'h00;
   localparam logic [7:0] CFG2_RESET     = 8'h40;
   localparam logic [7:0] CFG3_RESET     = 8'h00;
   localparam logic [7:0] FAULT_RESET    = 8'h00;
   localparam logic [1:0] AXI_OKAY       = 2'b00;
   localparam logic [1:0] AXI_SLVERR     = 2'b10;

endpackage : rss_pkg

// *** src/rss_delay_timer.sv ***
// one start-delay timer: counts while its start condition holds
module rss_delay_timer
   import rss_pkg::*;
#(
   parameter int unsigned C100 = CYC_100MS,
   parameter int unsigned C500 = CYC_500MS,
   parameter int unsigned C1S  = CYC_1S,
   parameter int unsigned C5S  = CYC_5S
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       start,
   input  wire logic [1:0] select,
   output logic            done
);
   import rss_pkg::*;

   logic [TMR_W-1:0] count;
   logic [TMR_W-1:0] limit;

   assign limit = (select == 2'b00) ? TMR_W'(C100 - 1) :
                  (select == 2'b01) ? TMR_W'(C500 - 1) :
                  (select == 2'b10) ? TMR_W'(C1S - 1)  : TMR_W'(C5S - 1);

   // withdrawing start restarts from zero [RQ23]
   always_ff @(posedge aclk) begin
      if (!aresetn || !start) begin
         count <= '0;
         done  <= 1'b0;
      end else if (!done) begin
         if (count >= limit) begin
            done <= 1'b1;
         end else begin
            count <= count + TMR_W'(1);
         end
      end
   end
endmodule : rss_delay_timer

// *** src/rss_sequencer.sv ***
// rail sequencer and reset supervisor with axi4-lite registers
// Summary of operation
// [RQ1] reset asserts only after power good and all rails good plus delay
// [RQ2] reset delay select: 100 ms, 500 ms, 1 s, 5 s
// [RQ3] low rail enable drives its rail good active after its delay
// [RQ4] each rail has its own delay select of the same four values
// [RQ5] rail good stays active while enable low, drops when enable high
// [RQ6] hot manual reset low forces gate off
// [RQ7] hot manual reset low clears shutdown register and retry failure
// [RQ8] hot manual reset high releases override, gate follows normal control
// [RQ9] other party holds hot manual reset low at least 5 us
// [RQ10] cold manual reset high forces power good inactive
// [RQ11] cold manual reset leaves gate control untouched
// [RQ12] other party holds cold manual reset high at least 5 us
// [RQ13] fault record loads all zeros at power up
// [RQ14] failure clears its fault bit; it stays zero until rewritten
// [RQ15] rail fault bit clears when that rail good goes active
// [RQ16] software writes all ones to fault record before monitoring
// [RQ17] software reads fault record after reset, then re-arms it
// [RQ18] writing AAh to shutdown register forces gate off
// [RQ19] writing 00h removes override, gate restarts power up
// [RQ20] shutdown register volatile, powers up zero
// [RQ21] software writes only AAh or 00h; register is write only
// [RQ22] fault bits: ov 7, uv 6, oc 5, retry 4, rails 3..0
// [RQ23] delay timers count clocks and restart when start withdrawn
// [RQ24] power good, gate and fault inputs sampled each clock
module rss_sequencer
   import rss_pkg::*;
#(
   parameter int unsigned NUM_RAILS = 4,
   parameter int unsigned C100      = CYC_100MS,
   parameter int unsigned C500      = CYC_500MS,
   parameter int unsigned C1S       = CYC_1S,
   parameter int unsigned C5S       = CYC_5S
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // pins
   input  wire logic [NUM_RAILS-1:0] rail_enable_in_n,
   input  wire logic                 hot_side_manual_reset_n,
   input  wire logic                 cold_side_manual_reset,
   // from the analog hot-swap side, same clock
   input  wire logic                 power_good_raw_n,
   input  wire logic                 gate_control_on,
   input  wire logic                 overvoltage,
   input  wire logic                 undervoltage,
   input  wire logic                 overcurrent,
   input  wire logic                 retry_failure,
   // outputs
   output logic [NUM_RAILS-1:0]      rail_good_out_n,
   output logic                      power_good_n,
   output logic                      gate_on,
   output logic                      system_reset,
   output logic                      retry_failure_flag
);
   import rss_pkg::*;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [NUM_RAILS-1:0] en_meta, en_sync;
   logic                 hot_meta, hot_sync;
   logic                 cold_meta, cold_sync;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_meta   <= '1;
         en_sync   <= '1;
         hot_meta  <= 1'b1;
         hot_sync  <= 1'b1;
         cold_meta <= 1'b0;
         cold_sync <= 1'b0;
      end else begin
         en_meta   <= rail_enable_in_n;
         en_sync   <= en_meta;
         hot_meta  <= hot_side_manual_reset_n;
         hot_sync  <= hot_meta;
         cold_meta <= cold_side_manual_reset;
         cold_sync <= cold_meta;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [7:0]           config_register_two;
   logic [7:0]           config_register_three;
   logic [7:0]           remote_shutdown_register;
   logic [7:0]           fault_record_register;
   logic [7:0]           next_fault;
   logic [7:0]           fault_event;
   logic [NUM_RAILS-1:0] rail_done;
   logic [NUM_RAILS-1:0] rail_good_q;
   logic                 pg_forced_n;
   logic                 all_good;
   logic                 reset_done;
   logic                 shut_override;

   // ***************************************************************
   // rail timers
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
         rss_delay_timer #(
            .C100 (C100),
            .C500 (C500),
            .C1S  (C1S),
            .C5S  (C5S)
         ) u_tmr (
            .aclk    (aclk),
            .aresetn (aresetn),
            .start   (!en_sync[gi]),                           // [RQ3] [RQ5]
            .select  (config_register_three[2*gi +: 2]),      // [RQ4]
            .done    (rail_done[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // power good, reset, gate
   // ***************************************************************
   assign pg_forced_n = power_good_raw_n | cold_sync;                      // [RQ10] [RQ24]
   assign all_good    = !pg_forced_n && (&rail_good_q);                    // [RQ1]

   rss_delay_timer #(
      .C100 (C100),
      .C500 (C500),
      .C1S  (C1S),
      .C5S  (C5S)
   ) u_rst_tmr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (all_good),                                                 // [RQ1]
      .select  (config_register_two[CFG2_RST_LSB +: 2]),                  // [RQ2]
      .done    (reset_done)
   );

   assign shut_override = (remote_shutdown_register == SHUT_ON);           // [RQ18] [RQ19]

   // gate ignores the cold-side reset entirely [RQ11]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rail_good_q  <= '0;
         power_good_n <= 1'b1;
         gate_on      <= 1'b0;
         system_reset <= 1'b0;
      end else begin
         rail_good_q  <= rail_done;                                        // [RQ3]
         power_good_n <= pg_forced_n;                                      // [RQ10]
         gate_on      <= gate_control_on && hot_sync && !shut_override;    // [RQ6] [RQ8]
         system_reset <= reset_done;                                       // [RQ1]
      end
   end

   assign rail_good_out_n = ~rail_good_q;

   // ***************************************************************
   // fault record
   // ***************************************************************
   assign fault_event = {overvoltage, undervoltage, overcurrent,
                         retry_failure_flag, rail_good_q[3:0]};            // [RQ22] [RQ15]

   // ***************************************************************
   // axi4-lite slave
   // ***************************************************************
   logic       aw_held, w_held;
   logic [7:0] aw_addr;
   logic [7:0] w_data;
   logic       w_lane0;
   logic       wr_fire;
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] rd_val;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit        = (aw_addr == ADDR_CFG2) || (aw_addr == ADDR_CFG3) ||
                          (aw_addr == ADDR_SHUTDOWN) || (aw_addr == ADDR_FAULT);
   // shutdown register is write only: it reads as an error [RQ21]
   assign rd_hit        = (s_axi_araddr == ADDR_CFG2) || (s_axi_araddr == ADDR_CFG3) ||
                          (s_axi_araddr == ADDR_FAULT) || (s_axi_araddr == ADDR_STATUS);
   assign rd_val = (s_axi_araddr == ADDR_CFG2)  ? config_register_two :
                   (s_axi_araddr == ADDR_CFG3)  ? config_register_three :
                   (s_axi_araddr == ADDR_FAULT) ? fault_record_register :
                   (s_axi_araddr == ADDR_STATUS) ?
                      {system_reset, power_good_n, gate_on, shut_override, rail_good_q[3:0]} :
                      8'h00;

   // a failure the same cycle as a software rewrite still clears the bit
   always_comb begin
      next_fault = fault_record_register;
      if (wr_fire && w_lane0 && aw_addr == ADDR_FAULT) begin
         next_fault = w_data;                                              // [RQ17]
      end
      next_fault[FLT_OV]    = next_fault[FLT_OV] & ~fault_event[FLT_OV];   // [RQ14] [RQ24]
      next_fault[FLT_UV]    = next_fault[FLT_UV] & ~fault_event[FLT_UV];
      next_fault[FLT_OC]    = next_fault[FLT_OC] & ~fault_event[FLT_OC];
      next_fault[FLT_RETRY] = next_fault[FLT_RETRY] & ~fault_event[FLT_RETRY];
      next_fault[3:0]       = next_fault[3:0] & ~fault_event[3:0];         // [RQ15]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= AXI_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            s_axi_rdata  <= {24'h00_0000, rd_val};
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // register storage
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         config_register_two      <= CFG2_RESET;
         config_register_three    <= CFG3_RESET;
         remote_shutdown_register <= SHUT_OFF;                             // [RQ20]
         fault_record_register    <= FAULT_RESET;                          // [RQ13]
         retry_failure_flag       <= 1'b0;
      end else begin
         fault_record_register <= next_fault;
         if (wr_fire && w_lane0 && aw_addr == ADDR_CFG2) begin
            config_register_two <= w_data;
         end
         if (wr_fire && w_lane0 && aw_addr == ADDR_CFG3) begin
            config_register_three <= w_data;
         end
         if (!hot_sync) begin
            remote_shutdown_register <= SHUT_OFF;                          // [RQ7]
         end else if (wr_fire && w_lane0 && aw_addr == ADDR_SHUTDOWN) begin
            remote_shutdown_register <= w_data;                            // [RQ18] [RQ19]
         end
         // a retry failure during hot reset still sets the flag: the event wins
         if (retry_failure) begin
            retry_failure_flag <= 1'b1;
         end else if (!hot_sync) begin
            retry_failure_flag <= 1'b0;                                    // [RQ7]
         end
      end
   end

endmodule : rss_sequencer

// *** testbench/rss_partner.sv ***
// converter chain and enable wiring model for the sequencer bench
module rss_partner (
   input  wire logic       aclk,
   input  wire logic       power_good_n,
   input  wire logic [3:0] rail_good_out_n,
   input  wire logic       relay,
   input  wire logic       hold_off,
   output logic      [3:0] rail_enable_in_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] next_en;
   // relay: converter 0 starts on power good, each later one only once the one before it is good
   assign next_en = relay ? {rail_good_out_n[2:0], power_good_n} : {4{power_good_n}};
   initial rail_enable_in_n = 4'hF;
   always @(posedge aclk) begin
      rail_enable_in_n <= next_en | {4{hold_off}};
   end
endmodule : rss_partner

// *** testbench/rss_sequencer_asserts.sv ***
// port-level checks for the rail sequencer
module rss_sequencer_asserts
   import rss_pkg::*;
#(
   parameter int unsigned C100 = 10
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic [3:0]  rail_enable_in_n,
   input wire logic        hot_side_manual_reset_n,
   input wire logic        cold_side_manual_reset,
   input wire logic        gate_control_on,
   input wire logic        retry_failure,
   input wire logic [3:0]  rail_good_out_n,
   input wire logic        power_good_n,
   input wire logic        gate_on,
   input wire logic        system_reset,
   input wire logic        retry_failure_flag
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // run length of the all-good state; the reset may not rise before it is long enough
   int unsigned good_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn || power_good_n || rail_good_out_n != 4'h0) good_cnt <= 0;
      else good_cnt <= good_cnt + 1;
   end
   a_reset_after_good: assert property ($rose(system_reset) |-> good_cnt >= C100)
      else $error("reset rose before the good delay");
   a_rail_good_wait: assert property ($fell(rail_good_out_n[0]) |-> !$past(rail_enable_in_n[0], C100))
      else $error("rail good before its delay");
   a_rail_good_drop: assert property (rail_enable_in_n[0] [*6] |-> rail_good_out_n[0])
      else $error("rail good held with enable high");
   a_gate_hot_off: assert property (!hot_side_manual_reset_n [*6] |-> !gate_on)
      else $error("gate on during hot reset");
   a_retry_flag_clear: assert property ((!hot_side_manual_reset_n && !retry_failure) [*6] |-> !retry_failure_flag)
      else $error("retry flag survived hot reset");
   a_gate_needs_req: assert property (gate_on |-> $past(gate_control_on))
      else $error("gate on without request");
   a_pg_cold_forced: assert property (cold_side_manual_reset [*5] |-> power_good_n)
      else $error("power good active during cold reset");
   a_err_read_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   c_reset_rise: cover property ($rose(system_reset));
   c_gate_fall: cover property ($fell(gate_on));
   c_retry_flag: cover property ($rose(retry_failure_flag));
endmodule : rss_sequencer_asserts

bind rss_sequencer rss_sequencer_asserts #(.C100(C100)) chk_u (.aclk, .aresetn, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .rail_enable_in_n, .hot_side_manual_reset_n,
   .cold_side_manual_reset, .gate_control_on, .retry_failure, .rail_good_out_n,
   .power_good_n, .gate_on, .system_reset, .retry_failure_flag);

// *** testbench/rss_sequencer_tb_top.sv ***
// self-checking bench for the rail sequencer
module rss_sequencer_tb_top;
   import rss_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CA = 10, CB = 20, CC = 30, CD = 40;
   logic        aclk = 1'h0, aresetn = 1'h0, relay = 1'h0, hold_off = 1'h1;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, fexp;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = '1, rail_enable_in_n, rail_good_out_n, flt = '0, rg_q = '1;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
   logic        s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, hot_side_manual_reset_n = '1, cold_side_manual_reset = '0;
   logic        power_good_raw_n = '1, gate_control_on = '0, pg_q = '1, sr_q = '0;
   logic        power_good_n, gate_on, system_reset, retry_failure_flag;
   int          bad_count = 0, cmp_count = 0, cyc = 0, t_pg = 0, t_sr = 0;
   int          t_rg [4];
   rss_sequencer #(.C100(CA), .C500(CB), .C1S(CC), .C5S(CD)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rail_enable_in_n, .hot_side_manual_reset_n,
      .cold_side_manual_reset, .power_good_raw_n, .gate_control_on, .overvoltage(flt[3]),
      .undervoltage(flt[2]), .overcurrent(flt[1]), .retry_failure(flt[0]), .rail_good_out_n,
      .power_good_n, .gate_on, .system_reset, .retry_failure_flag);
   rss_partner part_u (.aclk, .power_good_n, .rail_good_out_n, .relay, .hold_off,
      .rail_enable_in_n);
   always #12.5 aclk = ~aclk;
   // edge stamps of the outputs, for delay checks
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      rg_q <= rail_good_out_n;
      pg_q <= power_good_n;
      sr_q <= system_reset;
      for (int i = 0; i < 4; i++) if (rg_q[i] === 1'h1 && rail_good_out_n[i] === 1'h0) t_rg[i] <= cyc;
      if (pg_q === 1'h1 && power_good_n === 1'h0) t_pg <= cyc;
      if (sr_q === 1'h0 && system_reset === 1'h1) t_sr <= cyc;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic wt_reset;
      for (int k = 0; k < 400 && system_reset !== 1'h1; k++) @(posedge aclk);
      chk(system_reset, 1'h1);
      // one more edge so the stamps taken at this edge have landed
      @(posedge aclk);
   endtask : wt_reset
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      wrap_up();
   end
   // ********
   // main sequence
   // ********
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ADDR_FAULT, {24'h0, FAULT_RESET}, AXI_OKAY);
      rd(ADDR_CFG2, {24'h0, CFG2_RESET}, AXI_OKAY);
      rd(ADDR_SHUTDOWN, 32'h0, AXI_SLVERR);
      rd(8'h40, 32'h0, AXI_SLVERR);
      wr(8'h40, 32'hFF, AXI_SLVERR);
      wr(ADDR_FAULT, 32'hFF, AXI_OKAY);
      rd(ADDR_FAULT, 32'hFF, AXI_OKAY);
      wr(ADDR_CFG3, 32'hE4, AXI_OKAY);
      wr(ADDR_CFG2, {24'h0, CFG2_RESET | 8'h1 << CFG2_RST_LSB}, AXI_OKAY);
      gate_control_on <= 1'h1;
      power_good_raw_n <= 1'h0;
      hold_off <= 1'h0;
      wt_reset();
      chk_rng(t_rg[0] - t_pg, CA + 2, CA + 7);
      chk_rng(t_rg[1] - t_pg, CB + 2, CB + 7);
      chk_rng(t_rg[2] - t_pg, CC + 2, CC + 7);
      chk_rng(t_rg[3] - t_pg, CD + 2, CD + 7);
      chk_rng(t_sr - t_rg[3], CB + 1, CB + 3);
      rd(ADDR_FAULT, 32'hF0, AXI_OKAY);
      rd(ADDR_CFG3, 32'hE4, AXI_OKAY);
      // status: reset high, power good low, gate on, no override, all rails good
      rd(ADDR_STATUS, 32'hAF, AXI_OKAY);
      fexp = 8'hF0;
      for (int k = 0; k < 4; k++) begin
         flt <= 4'h1 << k;
         @(posedge aclk);
         flt <= '0;
         fexp = fexp & ~(8'h1 << (FLT_RETRY + k));
         rd(ADDR_FAULT, {24'h0, fexp}, AXI_OKAY);
      end
      chk(retry_failure_flag, 1'h1);
      wr(ADDR_SHUTDOWN, {24'h0, SHUT_ON}, AXI_OKAY);
      repeat (4) @(posedge aclk);
      chk(gate_on, 1'h0);
      wr(ADDR_SHUTDOWN, {24'h0, SHUT_OFF}, AXI_OKAY);
      repeat (4) @(posedge aclk);
      chk(gate_on, 1'h1);
      wr(ADDR_SHUTDOWN, {24'h0, SHUT_ON}, AXI_OKAY);
      hot_side_manual_reset_n <= 1'h0;
      repeat (200) @(posedge aclk);
      chk(gate_on, 1'h0);
      chk(retry_failure_flag, 1'h0);
      hot_side_manual_reset_n <= 1'h1;
      repeat (6) @(posedge aclk);
      chk(gate_on, 1'h1);
      cold_side_manual_reset <= 1'h1;
      repeat (200) @(posedge aclk);
      chk(power_good_n, 1'h1);
      chk(gate_on, 1'h1);
      chk(system_reset, 1'h0);
      cold_side_manual_reset <= 1'h0;
      repeat (6) @(posedge aclk);
      chk(power_good_n, 1'h0);
      // let the rails come good again so their drop below means something
      repeat (CD + 6) @(posedge aclk);
      chk(rail_good_out_n, 4'h0);
      hold_off <= 1'h1;
      repeat (8) @(posedge aclk);
      chk(rail_good_out_n, 4'hF);
      // two short enables that together exceed the delay must not make a rail good
      for (int k = 0; k < 2; k++) begin
         hold_off <= 1'h0;
         repeat (CA - 3) @(posedge aclk);
         hold_off <= 1'h1;
         repeat (3) @(posedge aclk);
      end
      repeat (CA) @(posedge aclk);
      chk(rail_good_out_n, 4'hF);
      wr(ADDR_CFG2, {24'h0, CFG2_RESET | 8'h3 << CFG2_RST_LSB}, AXI_OKAY);
      relay <= 1'h1;
      hold_off <= 1'h0;
      wt_reset();
      chk_rng(t_rg[3] - t_rg[2], CD + 2, CD + 8);
      chk_rng(t_sr - t_rg[3], CD + 1, CD + 3);
      wrap_up();
   end
endmodule : rss_sequencer_tb_top
